/* File: eip_map.svh */
// Function
// (R1) Unmasked request on an input delivers that input's own vector entry.
// (R2) Each request input is synchronized; edge or level detection per input.
// (R3) A source holds its request asserted until the device acknowledges it.
// (R4) Slave mode: type-present strobe captures the interrupt type off the bus.
// (R5) Slave mode: master raises request zero before the type-present strobe.
// (R6) Slave mode: device drives a request output toward the master.
// (R7) Cascade on request zero turns pin two into acknowledge output zero.
// (R8) Cascade on request one turns pin three into acknowledge output one.
// (R9) Cascade mode: acknowledge output asserted while the type is needed.
// (R10) Cascade mode: requesting peripheral supplies the type on acknowledge.
// (R11) Demodulation: input feeds timer zero and request two, inverse the others.
// (R12) Demodulation: request four marks each high-to-low demodulator transition.
// (R13) Demodulation: external timer and request-four pins are ignored internally.
// (R14) Level of the shared request-two pin reads in GPIO data bit 31.
// (R15) Software bits select mask, edge/level, cascade, slave and demodulation.
// (R16) Each asynchronous input passes two system-clock flip-flops first.
`ifndef EIP_MAP_SVH
`define EIP_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define EIP_OFS_CTRL 12'h000
`define EIP_OFS_PEND 12'h004
`define EIP_OFS_VEC 12'h008
`define EIP_OFS_PINS 12'h00c
`define EIP_OFS_ISTAT 12'h010
`define EIP_OFS_IMASK 12'h014

// ----------------------------------------
// Control field positions and reset
// ----------------------------------------
`define EIP_CTRL_MASK_LSB 0
`define EIP_CTRL_LVL_LSB 5
`define EIP_CTRL_CASC0 10
`define EIP_CTRL_CASC1 11
`define EIP_CTRL_SLAVE 12
`define EIP_CTRL_DEMOD 13
`define EIP_CTRL_W 14
`define EIP_CTRL_RST 14'h001f

// ----------------------------------------
// Status events and pin readback bits
// ----------------------------------------
`define EIP_EV_ACK 0
`define EIP_EV_TYPE 1
`define EIP_EV_FALL 2
`define EIP_EV_W 3
`define EIP_PIN_B31 31
`define EIP_PIN_B30 30
`define EIP_VEC_BASE_DEF 8'h20

`endif

/* File: eip_pkg.sv */
package eip_pkg;

  // Acknowledge sequence states
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_CASC = 2'b01
  } eip_state_type;

  // Interrupt type as delivered to the core
  typedef logic [7:0] eip_vec_type;

endpackage

/* File: eip_sync.sv */
`timescale 1ns/1ps
module eip_sync #(
  parameter int W = 7
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);
  logic [W-1:0] s1_q, s1_d;
  logic [W-1:0] s2_q, s2_d;

  // Two stages; only the second stage leaves this module
  always_comb
  begin
    s1_d = D;
    s2_d = s1_q;
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign Q = s2_q;
endmodule

/* File: eip_top.sv */
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "eip_map.svh"
module eip_top #(
  parameter logic [7:0] VEC_BASE = `EIP_VEC_BASE_DEF
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  input wire logic EXT_REQUEST_ZERO,
  input wire logic EXT_REQUEST_ONE,
  input wire logic EXT_REQUEST_TWO_I,
  output logic EXT_REQUEST_TWO_O,
  output logic EXT_REQUEST_TWO_OE,
  input wire logic EXT_REQUEST_THREE_I,
  output logic EXT_REQUEST_THREE_O,
  output logic EXT_REQUEST_THREE_OE,
  input wire logic EXT_REQUEST_FOUR,
  input wire logic TIMER_ZERO_PIN,
  input wire logic TIMER_ONE_PIN,
  output logic TIMER_ZERO_INPUT,
  output logic TIMER_ONE_INPUT,
  input wire logic [7:0] AD_BUS,
  input wire logic TYPE_STROBE,
  input wire logic INTERNAL_REQ,
  output logic CPU_INT_REQ,
  input wire logic CPU_INTA,
  output eip_pkg::eip_vec_type CPU_VECTOR,
  output logic CPU_VECTOR_VALID
);
  import eip_pkg::*;

  // ----------------------------------------
  // Synchronised pins
  // ----------------------------------------
  logic [6:0] raw;
  logic [6:0] s;
  logic [6:0] s_prev_q, s_prev_d;

  assign raw = {TIMER_ONE_PIN, TIMER_ZERO_PIN, EXT_REQUEST_FOUR,
                EXT_REQUEST_THREE_I, EXT_REQUEST_TWO_I,
                EXT_REQUEST_ONE, EXT_REQUEST_ZERO};

  // (R16) two-flop synchroniser
  eip_sync #(.W(7)) u_sync (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .D(raw),
    .Q(s)
  );

  // ----------------------------------------
  // State declarations
  // ----------------------------------------
  logic [`EIP_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [4:0] pend_q, pend_d;
  logic [`EIP_EV_W-1:0] istat_q, istat_d;
  logic [`EIP_EV_W-1:0] imask_q, imask_d;
  eip_state_type st_q, st_d;
  eip_vec_type vec_q, vec_d;
  eip_vec_type type_q, type_d;
  logic vval_q, vval_d;
  logic [2:0] chan_q, chan_d;
  logic ack0_q, ack0_d;
  logic ack1_q, ack1_d;
  logic sirq_q, sirq_d;
  logic req_q, req_d;
  logic tim0_q, tim0_d;
  logic tim1_q, tim1_d;

  logic [4:0] mask, lvl;
  logic casc0, casc1, slave, demod;
  logic pulse_demod_input;
  logic [4:0] src, set, clr, cand;
  logic any;
  logic [2:0] idx;
  logic sel_rise;
  logic wr, rd;
  logic [`EIP_EV_W-1:0] ev;

  assign mask = ctrl_q[`EIP_CTRL_MASK_LSB +: 5];
  assign lvl = ctrl_q[`EIP_CTRL_LVL_LSB +: 5];
  assign casc0 = ctrl_q[`EIP_CTRL_CASC0];
  assign casc1 = ctrl_q[`EIP_CTRL_CASC1];
  assign slave = ctrl_q[`EIP_CTRL_SLAVE];
  assign demod = ctrl_q[`EIP_CTRL_DEMOD];
  assign pulse_demod_input = s[2];

  // Lowest index wins among candidates
  function automatic logic [2:0] pick(input logic [4:0] v);
    logic [2:0] r;
    r = 3'd0;
    for (int i = 4; i >= 0; i--)
    begin
      if (v[i])
        r = 3'(i);
    end
    return r;
  endfunction

  // ----------------------------------------
  // Request sources and detection
  // ----------------------------------------
  // (R11) demodulator drives request two, inverse request four
  // (R13) request-four pin unused while demodulating
  always_comb
  begin
    src = s[4:0];
    src[2] = pulse_demod_input;
    src[4] = demod ? ~pulse_demod_input : s[4];
    set = '0;
    for (int i = 0; i < 5; i++)
    begin
      // (R2) edge or level per input
      if (lvl[i])
        set[i] = src[i];
      else
        set[i] = src[i] & ~s_prev_q[i];
    end
    // (R12) falling demodulator edge always sets four
    if (demod)
      set[4] = ~pulse_demod_input & s_prev_q[2];
    // Pins turned into outputs cannot request
    if (casc0)
      set[2] = 1'b0;
    if (casc1 || slave)
      set[3] = 1'b0;
    // Slave mode: request one pin is the type strobe
    if (slave)
      set[1] = 1'b0;
  end

  // Candidates for the core after masking
  always_comb
  begin
    cand = pend_q & ~mask;
    any = |cand;
    idx = pick(cand);
  end

  // Type-present strobe on request-one pin
  assign sel_rise = slave & s[1] & ~s_prev_q[1];

  // ----------------------------------------
  // Acknowledge sequence
  // ----------------------------------------
  always_comb
  begin
    st_d = st_q;
    vec_d = vec_q;
    vval_d = 1'b0;
    chan_d = chan_q;
    ack0_d = 1'b0;
    ack1_d = 1'b0;
    clr = '0;
    type_d = type_q;
    // (R4) capture type while strobe announces it
    if (sel_rise)
      type_d = AD_BUS;
    case (st_q)
      ST_IDLE:
      begin
        if (CPU_INTA && any)
        begin
          clr[idx] = 1'b1;
          chan_d = idx;
          if ((idx == 3'd0 && casc0) || (idx == 3'd1 && casc1))
          begin
            st_d = ST_CASC;
            ack0_d = (idx == 3'd0);
            ack1_d = (idx == 3'd1);
          end
          else
          begin
            vval_d = 1'b1;
            // (R1) vector entry of the chosen input; slave mode delivers the captured type instead
            if (slave)
              vec_d = type_q;
            else
              vec_d = VEC_BASE + 8'(idx);
          end
        end
      end
      ST_CASC:
      begin
        // (R9) acknowledge held until type arrives
        ack0_d = (chan_q == 3'd0);
        ack1_d = (chan_q == 3'd1);
        // (R10) peripheral places type with strobe
        if (TYPE_STROBE)
        begin
          vec_d = AD_BUS;
          vval_d = 1'b1;
          ack0_d = 1'b0;
          ack1_d = 1'b0;
          st_d = ST_IDLE;
        end
      end
      default:
      begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Pending flags and pin outputs
  // ----------------------------------------
  // Set wins over the acknowledge clear
  always_comb
  begin
    pend_d = (pend_q & ~clr) | set;
    if (wr && PADDR == `EIP_OFS_PEND)
      pend_d = (pend_d & ~PWDATA[4:0]) | set;
    s_prev_d = s;
    // (R6) request to the external master
    sirq_d = slave & INTERNAL_REQ;
    req_d = any & (st_q == ST_IDLE);
    // (R11) demodulator routed to the timers
    tim0_d = demod ? pulse_demod_input : s[5];
    tim1_d = demod ? ~pulse_demod_input : s[6];
  end

  // (R7) pin two becomes acknowledge zero
  assign EXT_REQUEST_TWO_OE = casc0;
  assign EXT_REQUEST_TWO_O = ack0_q;
  // (R8) pin three becomes acknowledge one
  assign EXT_REQUEST_THREE_OE = casc1 | slave;
  assign EXT_REQUEST_THREE_O = slave ? sirq_q : ack1_q;

  // ----------------------------------------
  // APB slave and interrupt status
  // ----------------------------------------
  // Zero-wait slave: every access completes in its first access cycle
  assign wr = PSEL & PENABLE & PWRITE;
  assign rd = PSEL & PENABLE & ~PWRITE;
  assign PREADY = 1'b1;

  always_comb
  begin
    ev = '0;
    ev[`EIP_EV_ACK] = vval_d;
    ev[`EIP_EV_TYPE] = sel_rise;
    ev[`EIP_EV_FALL] = demod & ~pulse_demod_input & s_prev_q[2];
    ctrl_d = ctrl_q;
    imask_d = imask_q;
    istat_d = istat_q;
    // (R15) configuration written by software
    if (wr && PADDR == `EIP_OFS_CTRL)
      ctrl_d = PWDATA[`EIP_CTRL_W-1:0];
    if (wr && PADDR == `EIP_OFS_IMASK)
      imask_d = PWDATA[`EIP_EV_W-1:0];
    // Read clears, but a same-cycle event survives
    if (rd && PADDR == `EIP_OFS_ISTAT)
      istat_d = '0;
    istat_d = istat_d | ev;
  end

  // Read mux; unmapped addresses answer with an error
  always_comb
  begin
    PRDATA = '0;
    PSLVERR = 1'b0;
    if (PADDR == `EIP_OFS_CTRL)
      PRDATA[`EIP_CTRL_W-1:0] = ctrl_q;
    else if (PADDR == `EIP_OFS_PEND)
      PRDATA[4:0] = pend_q;
    else if (PADDR == `EIP_OFS_VEC)
      PRDATA[7:0] = vec_q;
    else if (PADDR == `EIP_OFS_PINS)
    begin
      // (R14) shared pin level as GPIO bit 31
      PRDATA[`EIP_PIN_B31] = s[2];
      PRDATA[`EIP_PIN_B30] = s[4];
    end
    else if (PADDR == `EIP_OFS_ISTAT)
      PRDATA[`EIP_EV_W-1:0] = istat_q;
    else if (PADDR == `EIP_OFS_IMASK)
      PRDATA[`EIP_EV_W-1:0] = imask_q;
    else
      PSLVERR = PSEL & PENABLE;
  end

  assign IRQ = |(istat_q & imask_q);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      ctrl_q <= `EIP_CTRL_RST;
      pend_q <= '0;
      istat_q <= '0;
      imask_q <= '0;
      st_q <= ST_IDLE;
      vec_q <= '0;
      type_q <= '0;
      vval_q <= 1'b0;
      chan_q <= '0;
      ack0_q <= 1'b0;
      ack1_q <= 1'b0;
      sirq_q <= 1'b0;
      req_q <= 1'b0;
      tim0_q <= 1'b0;
      tim1_q <= 1'b0;
      s_prev_q <= '0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      pend_q <= pend_d;
      istat_q <= istat_d;
      imask_q <= imask_d;
      st_q <= st_d;
      vec_q <= vec_d;
      type_q <= type_d;
      vval_q <= vval_d;
      chan_q <= chan_d;
      ack0_q <= ack0_d;
      ack1_q <= ack1_d;
      sirq_q <= sirq_d;
      req_q <= req_d;
      tim0_q <= tim0_d;
      tim1_q <= tim1_d;
      s_prev_q <= s_prev_d;
    end
  end

  assign CPU_INT_REQ = req_q;
  assign CPU_VECTOR = vec_q;
  assign CPU_VECTOR_VALID = vval_q;
  assign TIMER_ZERO_INPUT = tim0_q;
  assign TIMER_ONE_INPUT = tim1_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence plain_ack;
    st_q == ST_IDLE && CPU_INTA && any && !slave &&
      !(idx == 3'd0 && casc0) && !(idx == 3'd1 && casc1);
  endsequence

  sequence vec_out(logic [2:0] i);
    CPU_VECTOR_VALID && CPU_VECTOR == VEC_BASE + 8'(i);
  endsequence

  property p_vec;
    logic [2:0] i;
    @(posedge CLK) disable iff (SYS_RST)
      (plain_ack, i = idx) |=> vec_out(i);
  endproperty
  chk_vector_entry: assert property (p_vec) // R1
    else $error("vector does not match input");

  chk_level_set: assert property (@(posedge CLK) disable iff (SYS_RST) // R2
    lvl[0] && src[0] |=> pend_q[0])
    else $error("level request not pending");

  chk_slave_capture: assert property (@(posedge CLK) // R4
    disable iff (SYS_RST) sel_rise |=> type_q == $past(AD_BUS))
    else $error("slave type not captured");

  chk_slave_request: assert property (@(posedge CLK) // R6
    disable iff (SYS_RST) slave && INTERNAL_REQ ##1 slave
      |-> EXT_REQUEST_THREE_OE && EXT_REQUEST_THREE_O)
    else $error("slave request not driven");

  chk_cascade_pin: assert property (@(posedge CLK) // R7
    disable iff (SYS_RST) casc0 |-> EXT_REQUEST_TWO_OE)
    else $error("pin two not acknowledge");

  chk_cascade1_pin: assert property (@(posedge CLK) // R8
    disable iff (SYS_RST) casc1 |-> EXT_REQUEST_THREE_OE)
    else $error("pin three not acknowledge");

  chk_cascade_ack: assert property (@(posedge CLK) // R9
    disable iff (SYS_RST) st_q == ST_CASC && !TYPE_STROBE
      |=> st_q == ST_CASC && (ack0_q != ack1_q))
    else $error("cascade acknowledge dropped early");

  chk_demod_timer: assert property (@(posedge CLK) // R11
    disable iff (SYS_RST) demod |=> TIMER_ZERO_INPUT == $past(pulse_demod_input)
      && TIMER_ONE_INPUT == !$past(pulse_demod_input))
    else $error("demodulator not on timers");

  chk_demod_fall: assert property (@(posedge CLK) // R12
    disable iff (SYS_RST) demod && $fell(pulse_demod_input) |=> pend_q[4])
    else $error("falling edge not on request four");
endmodule

/* File: eip_peer.sv */
`timescale 1ns/1ps
// ----
// Cascaded peripheral and slave-mode type source
// ----
module eip_peer (
  input wire logic CLK,
  input wire logic ACK,
  input wire logic SEL,
  input wire logic [7:0] TYPE_VAL,
  input wire logic [3:0] DLY,
  output logic [7:0] AD_BUS,
  output logic TYPE_STROBE
);
  logic [3:0] cnt_q;
  logic done_q;

  // Start quiet, bus shows junk
  initial
  begin
    cnt_q = 4'h0;
    done_q = 1'b0;
    AD_BUS = 8'h5a;
    TYPE_STROBE = 1'b0;
  end

  always @(posedge CLK)
  begin
    TYPE_STROBE <= 1'b0;
    if (!ACK)
    begin
      cnt_q <= 4'h0;
      done_q <= 1'b0;
    end
    else if (cnt_q != DLY)
      cnt_q <= cnt_q + 4'h1;
    else if (!done_q)
    begin
      TYPE_STROBE <= 1'b1;
      done_q <= 1'b1;
    end
    // Released bus toggles so stale data matches only on alternate cycles
    if (ACK || SEL)
      AD_BUS <= TYPE_VAL;
    else
      AD_BUS <= ~AD_BUS;
  end
endmodule

/* File: eip_top_bench.sv */
`timescale 1ns/1ps
`include "eip_map.svh"
`define CHK(a, b) \
  begin \
    cmp_count++; \
    if ((a) !== (b)) \
    begin \
      error_cnt++; \
      $display("ERROR %0t got %h exp %h", $time, a, b); \
    end \
  end
module eip_top_bench;
  import eip_pkg::*;
  localparam logic [7:0] VB = 8'h40;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] req;
  logic tmr0, tmr1, ireq, inta, cpu_req, vvalid, slave_b, ack_w, stb;
  logic two_o, two_oe, three_o, three_oe, t0_in, t1_in;
  logic [7:0] ad, tv;
  logic [3:0] dly;
  eip_vec_type vec;
  int seed, error_cnt, cmp_count, i, k, lvl;

  assign ack_w = (two_o & two_oe) | (three_o & three_oe & !slave_b);

  eip_top #(.VEC_BASE(VB)) i_dut (.CLK(clk), .SYS_RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
    .EXT_REQUEST_ZERO(req[0]), .EXT_REQUEST_ONE(req[1]),
    .EXT_REQUEST_TWO_I(two_oe ? two_o : req[2]), .EXT_REQUEST_TWO_O(two_o),
    .EXT_REQUEST_TWO_OE(two_oe),
    .EXT_REQUEST_THREE_I(three_oe ? three_o : req[3]),
    .EXT_REQUEST_THREE_O(three_o), .EXT_REQUEST_THREE_OE(three_oe),
    .EXT_REQUEST_FOUR(req[4]), .TIMER_ZERO_PIN(tmr0),
    .TIMER_ONE_PIN(tmr1), .TIMER_ZERO_INPUT(t0_in),
    .TIMER_ONE_INPUT(t1_in), .AD_BUS(ad), .TYPE_STROBE(stb),
    .INTERNAL_REQ(ireq), .CPU_INT_REQ(cpu_req), .CPU_INTA(inta),
    .CPU_VECTOR(vec), .CPU_VECTOR_VALID(vvalid));

  eip_peer i_peer (.CLK(clk), .ACK(ack_w), .SEL(req[1] & slave_b),
    .TYPE_VAL(tv), .DLY(dly), .AD_BUS(ad), .TYPE_STROBE(stb));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----
  // Tasks
  // ----
  task automatic print_verdict();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40)
    begin
      error_cnt++;
      $display("ERROR %0t bus transfer timed out", $time);
      print_verdict();
    end
  endtask

  // Bounded wait: 0 request, 1 vector valid, 2 cascade ack
  task automatic wait_on(input int s);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while ((s == 0 ? cpu_req : s == 1 ? vvalid : ack_w) !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      error_cnt++;
      $display("ERROR %0t wait %0d timed out", $time, s);
      print_verdict();
    end
  endtask

  task automatic pulse();
    inta <= 1'b1;
    @(posedge clk);
    inta <= 1'b0;
  endtask

  function automatic logic [7:0] exp_vec(input int n);
    return VB + 8'(n);
  endfunction

  // ----
  // Main sequence
  // ----
  initial
  begin
    {psel, penable, pwrite, inta, ireq, tmr0, tmr1, slave_b} = 8'h00;
    {paddr, pwdata, req, tv, dly} = '0;
    seed = 34;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `EIP_OFS_CTRL, 32'h0);
    `CHK(rd, 32'h0000001f)
    apb(1'b0, 12'h0f0, 32'h0);
    `CHK(er, 1'b1)
    apb(1'b1, `EIP_OFS_IMASK, 32'h1);
    // Random channel order, edge then level detection
    for (lvl = 0; lvl < 2; lvl++)
      for (k = 0; k < 5; k++)
      begin
        // Corner: each pass opens on channel zero
        i = (k == 0) ? 0 : $unsigned($random(seed)) % 5;
        apb(1'b1, `EIP_OFS_CTRL, lvl ? 32'h3e0 : 32'h0);
        req[i] <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(cpu_req, 1'b0)
        wait_on(0);
        pulse();
        wait_on(1);
        `CHK(vec, exp_vec(i))
        repeat (4) @(posedge clk);
        `CHK(cpu_req, lvl[0])
        `CHK(irq, 1'b1)
        req[i] <= 1'b0;
        repeat (4) @(posedge clk);
        apb(1'b1, `EIP_OFS_PEND, 32'h1f);
        apb(1'b0, `EIP_OFS_ISTAT, 32'h0);
        `CHK(rd[`EIP_EV_ACK], 1'b1)
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
      end
    // Masked input latches but does not request
    apb(1'b1, `EIP_OFS_CTRL, 32'h1f);
    req[4] <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(cpu_req, 1'b0)
    apb(1'b1, `EIP_OFS_CTRL, 32'h0);
    wait_on(0);
    pulse();
    wait_on(1);
    `CHK(vec, exp_vec(4))
    req[4] <= 1'b0;
    // Cascade on channel zero then one
    for (k = 0; k < 2; k++)
    begin
      tv <= 8'($random(seed));
      dly <= 4'($random(seed));
      apb(1'b1, `EIP_OFS_CTRL, k ? 32'h800 : 32'h400);
      apb(1'b1, `EIP_OFS_PEND, 32'h1f);
      req[k] <= 1'b1;
      wait_on(0);
      pulse();
      wait_on(2);
      `CHK({two_oe, three_oe}, k ? 2'b01 : 2'b10)
      wait_on(1);
      `CHK(vec, tv)
      req[k] <= 1'b0;
      repeat (4) @(posedge clk);
    end
    // Slave mode
    apb(1'b1, `EIP_OFS_CTRL, 32'h1000);
    apb(1'b1, `EIP_OFS_PEND, 32'h1f);
    slave_b <= 1'b1;
    ireq <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(three_o & three_oe, 1'b1)
    ireq <= 1'b0;
    tv <= 8'($random(seed));
    req[0] <= 1'b1;
    repeat (3) @(posedge clk);
    req[1] <= 1'b1;
    repeat (6) @(posedge clk);
    wait_on(0);
    pulse();
    wait_on(1);
    `CHK(vec, tv)
    apb(1'b0, `EIP_OFS_ISTAT, 32'h0);
    `CHK(rd[`EIP_EV_TYPE], 1'b1)
    req[1:0] <= 2'b00;
    slave_b <= 1'b0;
    // Demodulation routing
    apb(1'b1, `EIP_OFS_CTRL, 32'h2000);
    req[2] <= 1'b1;
    req[4] <= 1'b1;
    tmr1 <= 1'b1;
    tmr0 <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(t0_in, 1'b1)
    `CHK(t1_in, 1'b0)
    apb(1'b0, `EIP_OFS_PINS, 32'h0);
    `CHK(rd[`EIP_PIN_B31], 1'b1)
    `CHK(rd[`EIP_PIN_B30], 1'b1)
    apb(1'b0, `EIP_OFS_ISTAT, 32'h0);
    `CHK(rd[`EIP_EV_FALL], 1'b0)
    req[2] <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(t1_in, 1'b1)
    `CHK(t0_in, 1'b0)
    apb(1'b0, `EIP_OFS_ISTAT, 32'h0);
    `CHK(rd[`EIP_EV_FALL], 1'b1)
    print_verdict();
  end
endmodule
